//--- verilog/pit_pkg.sv
// package for the priority interrupt and trap unit
// assumes a 16-bit word machine with sixteen priority levels
package pit_pkg;
  localparam int N_LEVELS = 16;
  localparam int LEVEL_W = 4;
  localparam int WORD_W = 16;
  localparam int SUB_W = 6;
  localparam int N_SUBS = 64;
  // level assignments, level 0 highest priority
  localparam logic [3:0] LVL_POWER = 4'h0;
  localparam logic [3:0] LVL_PARITY = 4'h1;
  localparam logic [3:0] LVL_PROTECT = 4'h2;
  localparam logic [3:0] LVL_UNIMPL = 4'h4;
  localparam logic [3:0] LVL_FLOAT = 4'h5;
  localparam logic [3:0] LVL_DATA = 4'hC;
  localparam logic [3:0] LVL_SERVICE = 4'hD;
  // enables that survive master clear and cannot be cleared
  localparam logic [15:0] ENABLE_KEEP = 16'h0037;
  localparam logic [15:0] ENABLE_LOCK = 16'h0010;
  // dedicated memory locations
  localparam logic [15:0] RETURN_BASE = 16'h0020;
  localparam logic [15:0] DATA_ENTRY_BASE = 16'h0080;
  localparam logic [15:0] SERVICE_ENTRY_BASE = 16'h00C0;
  localparam logic [15:0] NO_ACTIVE_LOC = 16'h0000;
  // opcode groups that trap as unimplemented (5X only without the float option)
  localparam logic [3:0] OPG_MACRO1 = 4'h1;
  localparam logic [3:0] OPG_MACRO3 = 4'h3;
  localparam logic [3:0] OPG_MACRO5 = 4'h5;
  // program switch time
  localparam int CLK_MHZ = 200;
  localparam int SWITCH_NS = 2400;
  localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ) / 1000;
  localparam int SWC_W = 9;
  localparam logic [SWC_W-1:0] SWITCH_LAST = SWC_W'(SWITCH_CYC - 1);
  localparam logic [SWC_W-1:0] SWITCH_MID = SWC_W'(SWITCH_CYC / 2);
  // instruction codes on the command port
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SET_REQ = 4'h1,
    OP_RST_REQ = 4'h2,
    OP_SET_EN = 4'h3,
    OP_RST_EN = 4'h4,
    OP_SET_ACT = 4'h5,
    OP_RST_ACT = 4'h6,
    OP_CLR_RET = 4'h7,
    OP_CLR_ACT_RET = 4'h8
  } pit_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_LOAD = 2'b11,
    ST_HALT = 2'b10
  } pit_state_type;
endpackage : pit_pkg

//--- verilog/pit_sub_select.sv
// sub-level arbiter for one party-line level
// assumes requesting devices present a 64-bit request vector
`timescale 1ns/1ps
`default_nettype none
module pit_sub_select
  import pit_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // sampling
  input wire logic i_capture,
  input wire logic [N_SUBS-1:0] i_sub_req,
  // result
  output logic o_any,
  output logic [SUB_W-1:0] o_sub_id_reg
);
  logic [SUB_W-1:0] winner;
  logic [N_SUBS-1:0] lower_mask;
  assign o_any = |i_sub_req;
  // lowest index is the highest sub-level
  genvar g;
  generate
    for (g = 0; g < N_SUBS; g++) begin : g_mask
      if (g == 0) begin : g_first
        assign lower_mask[g] = 1'b0;
      end else begin : g_rest
        assign lower_mask[g] = lower_mask[g-1] | i_sub_req[g-1];
      end
    end
  endgenerate
  always_comb begin
    winner = '0;
    for (int i = N_SUBS - 1; i >= 0; i--) begin
      if (i_sub_req[i] && !lower_mask[i]) begin
        winner = SUB_W'(i);
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sub_id_reg <= '0;
    end else if (i_capture) begin
      o_sub_id_reg <= winner;
    end
  end
endmodule : pit_sub_select
`default_nettype wire

//--- verilog/pit_trap_unit.sv
// priority interrupt and trap unit: sixteen levels of request, enable, active
// assumes a cpu sequencer that issues one instruction code per cycle and
// performs the memory cycles this unit asks for
// Function
// - request set by signal or instr, cleared
// - enable set/reset by instr; gates requests
// - active set on interrupt, held till cleared
// - clear-active-return keeps the request bit
// - set/reset active without program switch
// - master clear keeps enables 0,1,2,4,5
// - interrupt when enabled, pending, unblocked, done
// - save pc, load entry, 2.4 us
// - clear-return clears top active, loads return
// - data level returns 38, entries from 80
// - service level returns 3A, entries C0-FF
// - sub-levels arbitrated, no mutual preemption
// - pending data request re-enters at once
// - four internal traps abort and request
// - unimplemented trap on exec request, 1X/3X, 5X without float option
// - pc held until level 4 active
// - unimplemented level enable locked on
// - parity error aborts; halt without level
// - protect write suppressed; branch then trap
// - unprotected privileged instr traps; key switch
// - exponent wrap flags overflow or underflow, blocks writeback
// - two dedicated words per level
// - level 0 highest priority
`timescale 1ns/1ps
`default_nettype none
module pit_trap_unit
  import pit_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // instruction port from the sequencer
  input wire logic [3:0] i_instr_op,
  input wire logic [LEVEL_W-1:0] i_instr_level,
  input wire logic i_instr_done,
  input wire logic [7:0] i_opcode,
  input wire logic i_opcode_valid,
  input wire logic i_exec_request,
  input wire logic i_float_option,
  // trap sources
  input wire logic i_parity_err,
  input wire logic i_parity_level_present,
  input wire logic i_protect_key,
  input wire logic i_code_unprotected,
  input wire logic i_write_protected,
  input wire logic i_branch_protected,
  input wire logic i_privileged_instr,
  input wire logic i_fp_exp_inc,
  input wire logic i_fp_exp_dec,
  input wire logic i_fp_exp_ones,
  input wire logic i_fp_exp_zero,
  // external requests and party lines
  input wire logic [N_LEVELS-1:0] i_ext_req,
  input wire logic [N_SUBS-1:0] i_data_sub_req,
  input wire logic [N_SUBS-1:0] i_service_sub_req,
  // memory cycle port
  input wire logic [WORD_W-1:0] i_pc,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  output logic o_mem_wr,
  output logic o_mem_rd,
  output logic [WORD_W-1:0] o_mem_addr,
  output logic [WORD_W-1:0] o_mem_wdata,
  output logic o_pc_load,
  output logic [WORD_W-1:0] o_pc_value,
  // control to the sequencer
  output logic o_abort,
  output logic o_pc_hold,
  output logic o_write_suppress,
  output logic o_fp_block,
  output logic o_halt,
  output logic o_switching,
  // level state
  output logic [N_LEVELS-1:0] o_request,
  output logic [N_LEVELS-1:0] o_enable,
  output logic [N_LEVELS-1:0] o_active
);
  logic [N_LEVELS-1:0] request_reg;
  logic [N_LEVELS-1:0] enable_reg;
  logic [N_LEVELS-1:0] active_reg;
  logic [N_LEVELS-1:0] set_req_next;
  logic [N_LEVELS-1:0] grant_onehot;
  logic [N_LEVELS-1:0] top_active_onehot;
  logic [N_LEVELS-1:0] eligible;
  logic [N_LEVELS-1:0] higher_active;
  logic [N_LEVELS-1:0] instr_sel;
  logic [N_LEVELS-1:0] pend_level;
  pit_state_type state_reg;
  logic [SWC_W-1:0] cnt_reg;
  logic [LEVEL_W-1:0] lvl_reg;
  logic [WORD_W-1:0] ret_addr_reg;
  logic [WORD_W-1:0] entry_addr_reg;
  logic [LEVEL_W-1:0] grant_lvl;
  logic [LEVEL_W-1:0] top_act_lvl;
  logic any_grant;
  logic any_active;
  logic start_switch;
  logic clr_ret;
  logic clr_act_ret;
  logic unimpl_trap;
  logic protect_trap;
  logic protect_write;
  logic fp_trap;
  logic unimpl_hold_reg;
  logic data_any;
  logic service_any;
  logic [SUB_W-1:0] data_sub;
  logic [SUB_W-1:0] service_sub;
  logic [WORD_W-1:0] mem_addr_reg;
  logic [WORD_W-1:0] mem_wdata_reg;
  logic [WORD_W-1:0] pc_value_reg;
  logic mem_wr_reg;
  logic mem_rd_reg;
  logic pc_load_reg;
  logic rd_wait_reg;
  logic ret_wait_reg;
  // party lines feed one request each
  pit_sub_select u_data_sel (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_capture(start_switch),
    .i_sub_req(i_data_sub_req),
    .o_any(data_any),
    .o_sub_id_reg(data_sub)
  );
  pit_sub_select u_service_sel (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_capture(start_switch),
    .i_sub_req(i_service_sub_req),
    .o_any(service_any),
    .o_sub_id_reg(service_sub)
  );
  // trap conditions
  assign unimpl_trap = i_opcode_valid && (i_exec_request ||
    i_opcode[7:4] == OPG_MACRO1 || i_opcode[7:4] == OPG_MACRO3 ||
    (i_opcode[7:4] == OPG_MACRO5 && !i_float_option));
  assign protect_write = i_protect_key && i_code_unprotected && i_write_protected;
  assign protect_trap = i_protect_key && i_code_unprotected &&
    (i_write_protected || i_branch_protected ||
    (i_privileged_instr && !i_exec_request));
  assign fp_trap = (i_fp_exp_inc && i_fp_exp_ones) ||
    (i_fp_exp_dec && i_fp_exp_zero);
  // branch completes before the trap, so no abort for branches
  assign o_abort = unimpl_trap || i_parity_err || protect_write ||
    (protect_trap && !i_branch_protected) || fp_trap;
  assign o_write_suppress = protect_write;
  assign o_fp_block = fp_trap;
  assign o_pc_hold = unimpl_trap || unimpl_hold_reg;
  always_comb begin
    set_req_next = i_ext_req;
    set_req_next[LVL_UNIMPL] = i_ext_req[LVL_UNIMPL] | unimpl_trap;
    set_req_next[LVL_PARITY] = i_ext_req[LVL_PARITY] |
      (i_parity_err & i_parity_level_present);
    set_req_next[LVL_PROTECT] = i_ext_req[LVL_PROTECT] | protect_trap;
    set_req_next[LVL_FLOAT] = i_ext_req[LVL_FLOAT] | fp_trap;
    set_req_next[LVL_DATA] = i_ext_req[LVL_DATA] | data_any;
    set_req_next[LVL_SERVICE] = i_ext_req[LVL_SERVICE] | service_any;
  end
  // priority: lower index wins
  genvar g;
  generate
    for (g = 0; g < N_LEVELS; g++) begin : g_lvl
      if (g == 0) begin : g_top
        assign higher_active[g] = 1'b0;
        assign pend_level[g] = 1'b0;
      end else begin : g_low
        assign higher_active[g] = higher_active[g-1] | active_reg[g-1];
        assign pend_level[g] = pend_level[g-1] | eligible[g-1];
      end
      assign eligible[g] = request_reg[g] & enable_reg[g] &
        ~higher_active[g] & ~active_reg[g];
      assign grant_onehot[g] = eligible[g] & ~pend_level[g];
      assign top_active_onehot[g] = active_reg[g] & ~higher_active[g];
      assign instr_sel[g] = (i_instr_level == LEVEL_W'(g));
    end
  endgenerate
  always_comb begin
    grant_lvl = '0;
    top_act_lvl = '0;
    for (int i = 0; i < N_LEVELS; i++) begin
      if (grant_onehot[i]) begin
        grant_lvl = LEVEL_W'(i);
      end
      if (top_active_onehot[i]) begin
        top_act_lvl = LEVEL_W'(i);
      end
    end
  end
  assign any_grant = |grant_onehot;
  assign any_active = |active_reg;
  assign clr_ret = (state_reg == ST_IDLE) && i_instr_op == OP_CLR_RET;
  assign clr_act_ret = (state_reg == ST_IDLE) && i_instr_op == OP_CLR_ACT_RET;
  // switch only between instructions; re-entry follows a return at once
  assign start_switch = (state_reg == ST_IDLE) && i_instr_done && any_grant &&
    !clr_ret && !clr_act_ret;
  // request flip-flops; set wins over clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      request_reg <= '0;
    end else begin
      for (int i = 0; i < N_LEVELS; i++) begin
        if (clr_ret && top_active_onehot[i]) begin
          request_reg[i] <= 1'b0;
        end
        if (i_instr_op == OP_RST_REQ && instr_sel[i]) begin
          request_reg[i] <= 1'b0;
        end
        if (start_switch && grant_onehot[i] && (i == LVL_DATA || i == LVL_SERVICE)) begin
          request_reg[i] <= 1'b0;
        end
        if (set_req_next[i] || (i_instr_op == OP_SET_REQ && instr_sel[i])) begin
          request_reg[i] <= 1'b1;
        end
      end
    end
  end
  // enable flip-flops
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable_reg <= ENABLE_KEEP;
    end else begin
      for (int i = 0; i < N_LEVELS; i++) begin
        if (i_instr_op == OP_SET_EN && instr_sel[i]) begin
          enable_reg[i] <= 1'b1;
        end else if (i_instr_op == OP_RST_EN && instr_sel[i] && !ENABLE_LOCK[i]) begin
          enable_reg[i] <= 1'b0;
        end
      end
    end
  end
  // active flip-flops
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      active_reg <= '0;
    end else begin
      for (int i = 0; i < N_LEVELS; i++) begin
        if ((clr_ret || clr_act_ret) && top_active_onehot[i]) begin
          active_reg[i] <= 1'b0;
        end else if (start_switch && grant_onehot[i]) begin
          active_reg[i] <= 1'b1;
        end else if (i_instr_op == OP_RST_ACT && instr_sel[i]) begin
          active_reg[i] <= 1'b0;
        end else if (i_instr_op == OP_SET_ACT && instr_sel[i]) begin
          active_reg[i] <= 1'b1;
        end
      end
    end
  end
  // unimplemented trap holds the pc until its level is active
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      unimpl_hold_reg <= 1'b0;
    end else if (active_reg[LVL_UNIMPL]) begin
      unimpl_hold_reg <= 1'b0;
    end else if (unimpl_trap) begin
      unimpl_hold_reg <= 1'b1;
    end
  end
  // switch sequencer; parity without its level halts
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      lvl_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (i_parity_err && !i_parity_level_present) begin
            state_reg <= ST_HALT;
          end else if (start_switch) begin
            state_reg <= ST_SAVE;
            lvl_reg <= grant_lvl;
          end
        end
        ST_SAVE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == SWITCH_MID) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == SWITCH_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_HALT: begin
          state_reg <= ST_HALT;
        end
      endcase
    end
  end
  assign o_halt = (state_reg == ST_HALT);
  assign o_switching = (state_reg == ST_SAVE) || (state_reg == ST_LOAD);
  // dedicated locations
  always_comb begin
    ret_addr_reg = RETURN_BASE + {11'h000, lvl_reg, 1'b0};
    if (lvl_reg == LVL_DATA) begin
      entry_addr_reg = DATA_ENTRY_BASE + {10'h000, data_sub};
    end else if (lvl_reg == LVL_SERVICE) begin
      entry_addr_reg = SERVICE_ENTRY_BASE + {10'h000, service_sub};
    end else begin
      entry_addr_reg = ret_addr_reg + 16'h0001;
    end
  end
  // memory cycles and pc loads
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      ret_wait_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
      pc_value_reg <= '0;
    end else begin
      mem_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      if (clr_ret || clr_act_ret) begin
        mem_rd_reg <= 1'b1;
        mem_addr_reg <= any_active ?
          (RETURN_BASE + {11'h000, top_act_lvl, 1'b0}) : NO_ACTIVE_LOC;
      end else if (state_reg == ST_SAVE && cnt_reg == '0) begin
        mem_wr_reg <= 1'b1;
        mem_addr_reg <= ret_addr_reg;
        mem_wdata_reg <= i_pc;
      end else if (state_reg == ST_LOAD && cnt_reg == SWITCH_MID + 1'b1) begin
        mem_rd_reg <= 1'b1;
        mem_addr_reg <= entry_addr_reg;
      end
      // read data stand only in the cycle after the strobe, so take them there
      rd_wait_reg <= mem_rd_reg;
      ret_wait_reg <= mem_rd_reg && (state_reg == ST_IDLE);
      if (rd_wait_reg) begin
        pc_value_reg <= i_mem_rdata;
      end
      if (state_reg == ST_LOAD && cnt_reg == SWITCH_LAST) begin
        pc_load_reg <= 1'b1;
      end else if (ret_wait_reg) begin
        pc_load_reg <= 1'b1;
      end
    end
  end
  assign o_mem_wr = mem_wr_reg;
  assign o_mem_rd = mem_rd_reg;
  assign o_mem_addr = mem_addr_reg;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_pc_load = pc_load_reg;
  assign o_pc_value = pc_value_reg;
  assign o_request = request_reg;
  assign o_enable = enable_reg;
  assign o_active = active_reg;
  // assertions
  property p_lock_enable;
    @(posedge i_core_clk) disable iff (i_sys_rst) enable_reg[LVL_UNIMPL];
  endproperty
  a_lock_enable: assert property (p_lock_enable) else $error("unimpl enable lost");
  property p_switch_len;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(o_switching) |-> o_switching [*8];
  endproperty
  a_switch_len: assert property (p_switch_len) else $error("switch too short");
  property p_switch_needs_en;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      start_switch |-> (enable_reg & request_reg) != '0;
  endproperty
  a_switch_needs_en: assert property (p_switch_needs_en) else $error("switch unqualified");
  property p_active_after;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      start_switch |=> active_reg[$past(grant_lvl)];
  endproperty
  a_active_after: assert property (p_active_after) else $error("active not set");
  property p_car_keeps_req;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (clr_act_ret && (request_reg & top_active_onehot) != '0) |=>
      (request_reg & $past(top_active_onehot)) != '0;
  endproperty
  a_car_keeps_req: assert property (p_car_keeps_req) else $error("request lost");
  property p_save_first;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(o_switching) |=> o_mem_wr && o_mem_addr == ret_addr_reg;
  endproperty
  a_save_first: assert property (p_save_first) else $error("return not saved");
  property p_halt_sticks;
    @(posedge i_core_clk) disable iff (i_sys_rst) o_halt |=> o_halt;
  endproperty
  a_halt_sticks: assert property (p_halt_sticks) else $error("halt released");
  property p_write_blocked;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_protect_key && i_code_unprotected && i_write_protected) |-> o_write_suppress && o_abort;
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("write not blocked");
endmodule : pit_trap_unit
`default_nettype wire

//--- bench/pit_cpu_model.sv
// cpu sequencer and memory model facing the trap unit
// assumes read data one cycle after a read strobe and pc loaded on the load pulse
`timescale 1ns/1ps
`default_nettype none
module pit_cpu_model (
  // clock
  input wire logic i_core_clk,
  // memory and pc requests from the unit
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  input wire logic [15:0] i_mem_wdata,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  // answers
  output logic [15:0] o_mem_rdata,
  output logic [15:0] o_pc
);
  logic [15:0] mem_reg [256];
  // unwritten words read as E0 and the low address byte
  initial begin
    for (int a = 0; a < 256; a++) begin
      mem_reg[a] = {8'hE0, 8'(a)};
    end
    o_mem_rdata = 16'h0000;
    o_pc = 16'h1000;
  end
  always @(posedge i_core_clk) begin
    if (i_mem_wr) begin
      mem_reg[i_mem_addr[7:0]] <= i_mem_wdata;
    end
  end
  // read data good one cycle only, then it flips so a late sample shows
  always @(posedge i_core_clk) begin
    o_mem_rdata <= i_mem_rd ? mem_reg[i_mem_addr[7:0]] : ~o_mem_rdata;
  end
  always @(posedge i_core_clk) begin
    if (i_pc_load) begin
      o_pc <= i_pc_value;
    end
  end
endmodule : pit_cpu_model
`default_nettype wire

//--- bench/tb_pit_trap_unit.sv
// self-checking bench for the priority interrupt and trap unit
// assumes the cpu model answers memory cycles; done is pulsed to end an instruction
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_pit_trap_unit
  import pit_pkg::*;
;
  logic i_core_clk, i_sys_rst, i_instr_done, i_opcode_valid, i_exec_request, i_float_option;
  logic [3:0] i_instr_op, i_instr_level;
  logic [7:0] i_opcode;
  logic i_parity_err, i_parity_level_present, i_protect_key, i_code_unprotected;
  logic i_write_protected, i_branch_protected, i_privileged_instr;
  logic i_fp_exp_inc, i_fp_exp_dec, i_fp_exp_ones, i_fp_exp_zero;
  logic [15:0] i_ext_req, i_pc, i_mem_rdata, o_mem_addr, o_mem_wdata, o_pc_value;
  logic [15:0] o_request, o_enable, o_active;
  logic [63:0] i_data_sub_req, i_service_sub_req;
  logic o_mem_wr, o_mem_rd, o_pc_load, o_abort, o_pc_hold, o_write_suppress, o_fp_block;
  logic o_halt, o_switching;
  logic [12:0] src;
  logic [15:0] pc7, pc3, pcx;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  typedef struct packed {logic [3:0] op; logic [3:0] lvl; logic [47:0] st;} row_type;
  typedef struct packed {logic [7:0] opc; logic [12:0] s; logic [2:0] f; logic [15:0] req;
    logic [3:0] lvl;} trap_row_type;
  row_type rows [9] = '{
    '{OP_SET_REQ, 4'h7, {16'h0080, 16'h0037, 16'h0000}},
    '{OP_SET_EN, 4'h7, {16'h0080, 16'h00B7, 16'h0000}},
    '{OP_RST_EN, 4'h4, {16'h0080, 16'h00B7, 16'h0000}},
    '{OP_SET_ACT, 4'h3, {16'h0080, 16'h00B7, 16'h0008}},
    '{OP_RST_ACT, 4'h3, {16'h0080, 16'h00B7, 16'h0000}},
    '{OP_RST_REQ, 4'h7, {16'h0000, 16'h00B7, 16'h0000}},
    '{OP_RST_EN, 4'h7, {16'h0000, 16'h0037, 16'h0000}},
    '{OP_SET_REQ, 4'hF, {16'h8000, 16'h0037, 16'h0000}},
    '{OP_RST_REQ, 4'hF, {16'h0000, 16'h0037, 16'h0000}}};
  // unimplemented opcodes 15, 3A, 52 are issued beside assigned 20 and 00
  trap_row_type trows [14] = '{
    '{8'h15, 13'h0001, 3'b100, 16'h0010, 4'h4}, '{8'h3A, 13'h0001, 3'b100, 16'h0010, 4'h4},
    '{8'h52, 13'h0001, 3'b100, 16'h0010, 4'h4}, '{8'h52, 13'h1001, 3'b000, 16'h0000, 4'h4},
    '{8'h20, 13'h0001, 3'b000, 16'h0000, 4'h4}, '{8'h20, 13'h0003, 3'b100, 16'h0010, 4'h4},
    '{8'h00, 13'h0004, 3'b100, 16'h0002, 4'h1}, '{8'h00, 13'h0818, 3'b110, 16'h0004, 4'h2},
    '{8'h00, 13'h0828, 3'b000, 16'h0004, 4'h2}, '{8'h00, 13'h0848, 3'b100, 16'h0004, 4'h2},
    '{8'h00, 13'h0048, 3'b000, 16'h0000, 4'h2}, '{8'h00, 13'h0180, 3'b101, 16'h0020, 4'h5},
    '{8'h00, 13'h0600, 3'b101, 16'h0020, 4'h5}, '{8'h00, 13'h0080, 3'b000, 16'h0000, 4'h5}};
  assign {i_float_option, i_protect_key, i_fp_exp_zero, i_fp_exp_dec, i_fp_exp_ones,
    i_fp_exp_inc, i_privileged_instr, i_branch_protected, i_write_protected,
    i_code_unprotected, i_parity_err, i_exec_request, i_opcode_valid} = src;
  pit_trap_unit pit_trap_unit_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_instr_op(i_instr_op), .i_instr_level(i_instr_level), .i_instr_done(i_instr_done),
    .i_opcode(i_opcode), .i_opcode_valid(i_opcode_valid), .i_exec_request(i_exec_request),
    .i_float_option(i_float_option), .i_parity_err(i_parity_err),
    .i_parity_level_present(i_parity_level_present), .i_protect_key(i_protect_key),
    .i_code_unprotected(i_code_unprotected), .i_write_protected(i_write_protected),
    .i_branch_protected(i_branch_protected), .i_privileged_instr(i_privileged_instr),
    .i_fp_exp_inc(i_fp_exp_inc), .i_fp_exp_dec(i_fp_exp_dec), .i_fp_exp_ones(i_fp_exp_ones),
    .i_fp_exp_zero(i_fp_exp_zero), .i_ext_req(i_ext_req), .i_data_sub_req(i_data_sub_req),
    .i_service_sub_req(i_service_sub_req), .i_pc(i_pc), .i_mem_rdata(i_mem_rdata),
    .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
    .o_abort(o_abort), .o_pc_hold(o_pc_hold), .o_write_suppress(o_write_suppress),
    .o_fp_block(o_fp_block), .o_halt(o_halt), .o_switching(o_switching),
    .o_request(o_request), .o_enable(o_enable), .o_active(o_active));
  pit_cpu_model pit_cpu_model_i (.i_core_clk(i_core_clk), .i_mem_wr(o_mem_wr),
    .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .i_pc_load(o_pc_load), .i_pc_value(o_pc_value), .o_mem_rdata(i_mem_rdata), .o_pc(i_pc));
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // whole run is about six switches of 480 cycles
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic op(input logic [3:0] c, input logic [3:0] l);
    @(posedge i_core_clk);
    i_instr_op <= c;
    i_instr_level <= l;
    @(posedge i_core_clk);
    i_instr_op <= OP_NONE;
  endtask : op
  task automatic pulse_done();
    @(posedge i_core_clk);
    i_instr_done <= 1'b1;
    @(posedge i_core_clk);
    i_instr_done <= 1'b0;
  endtask : pulse_done
  task automatic wait_ev(input int w);
    for (int n = 0; n < 600; n++) begin
      @(posedge i_core_clk);
      #1;
      if ((w == 0 && o_mem_wr) || (w == 1 && o_mem_rd) || (w == 2 && o_pc_load)) break;
    end
  endtask : wait_ev
  task automatic switch_chk(input logic [15:0] ret, input logic [15:0] ent,
    output logic [15:0] saved);
    int t0;
    pulse_done();
    wait_ev(0);
    saved = i_pc;
    t0 = cyc;
    `CHK({o_mem_wr, o_mem_addr, o_mem_wdata}, {1'b1, ret, saved})
    wait_ev(1);
    `CHK({o_mem_rd, o_mem_addr}, {1'b1, ent})
    wait_ev(2);
    `CHK({o_pc_load, o_pc_value}, {1'b1, 16'hE000 | ent})
    `CHK(cyc - t0, 479)
  endtask : switch_chk
  task automatic ret_chk(input logic [3:0] c, input logic [15:0] a, input logic [15:0] v);
    op(c, 4'h0);
    #1;
    `CHK({o_mem_rd, o_mem_addr}, {1'b1, a})
    repeat (2) @(posedge i_core_clk);
    #1;
    `CHK({o_pc_load, o_pc_value}, {1'b1, v})
  endtask : ret_chk
  task automatic rst_chk();
    i_sys_rst <= 1'b1;
    i_parity_level_present <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    #1;
    `CHK({o_request, o_enable, o_active, o_halt}, {32'h0000_0037, 16'h0, 1'b0})
  endtask : rst_chk
  initial begin
    {i_sys_rst, i_instr_op, i_instr_level, i_instr_done, i_opcode, src} = '0;
    {i_ext_req, i_data_sub_req, i_service_sub_req} = '0;
    i_parity_level_present = 1'b1;
    rst_chk();
    foreach (rows[k]) begin
      op(rows[k].op, rows[k].lvl);
      #1;
      `CHK({o_request, o_enable, o_active, o_switching}, {rows[k].st, 1'b0})
    end
    op(OP_SET_EN, 4'h7);
    @(posedge i_core_clk);
    i_ext_req <= 16'h0080;
    @(posedge i_core_clk);
    i_ext_req <= 16'h0000;
    repeat (10) @(posedge i_core_clk);
    #1;
    `CHK({o_request[7], o_switching}, 2'b10)
    switch_chk(16'h002E, 16'h002F, pc7);
    op(OP_SET_REQ, 4'h9);
    op(OP_SET_EN, 4'h9);
    pulse_done();
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK({o_switching, o_active}, {1'b0, 16'h0080})
    op(OP_SET_EN, 4'h3);
    op(OP_SET_REQ, 4'h3);
    switch_chk(16'h0026, 16'h0027, pc3);
    `CHK(o_active, 16'h0088)
    ret_chk(OP_CLR_RET, 16'h0026, pc3);
    `CHK({o_active, o_request[3]}, {16'h0080, 1'b0})
    op(OP_SET_REQ, 4'h7);
    ret_chk(OP_CLR_ACT_RET, 16'h002E, pc7);
    `CHK({o_active, o_request[7]}, {16'h0000, 1'b1})
    op(OP_RST_REQ, 4'h7);
    op(OP_RST_REQ, 4'h9);
    op(OP_SET_EN, 4'hC);
    op(OP_SET_EN, 4'hD);
    @(posedge i_core_clk);
    i_service_sub_req <= 64'h1;
    switch_chk(16'h003A, 16'h00C0, pcx);
    i_service_sub_req <= 64'h0;
    i_data_sub_req <= 64'h220;
    switch_chk(16'h0038, 16'h0085, pcx);
    i_data_sub_req <= 64'h200;
    ret_chk(OP_CLR_RET, 16'h0038, pcx);
    switch_chk(16'h0038, 16'h0089, pcx);
    i_data_sub_req <= 64'h4;
    pulse_done();
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK(o_switching, 1'b0)
    i_data_sub_req <= 64'h0;
    foreach (trows[k]) begin
      @(posedge i_core_clk);
      i_opcode <= trows[k].opc;
      src <= trows[k].s;
      #1;
      `CHK({o_abort, o_write_suppress, o_fp_block}, trows[k].f)
      @(posedge i_core_clk);
      src <= 13'h0;
      #1;
      `CHK(o_request & 16'h0036, trows[k].req)
      op(OP_RST_REQ, trows[k].lvl);
    end
    @(posedge i_core_clk);
    i_opcode <= 8'h15;
    src <= 13'h0001;
    @(posedge i_core_clk);
    src <= 13'h0;
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK(o_pc_hold, 1'b1)
    switch_chk(16'h0028, 16'h0029, pcx);
    `CHK({o_pc_hold, o_active[4]}, 2'b01)
    @(posedge i_core_clk);
    i_parity_level_present <= 1'b0;
    src <= 13'h0004;
    @(posedge i_core_clk);
    src <= 13'h0;
    repeat (20) @(posedge i_core_clk);
    #1;
    `CHK({o_halt, o_switching}, 2'b10)
    @(posedge i_core_clk);
    rst_chk();
    close_out();
  end
endmodule : tb_pit_trap_unit
`default_nettype wire
